// ### rtl/irwc_pkg.sv
// Constants and types for the interrupt routing and wake control block
// Function
// RULE1: Orientation bypassed in sleep unless bit5 set
// RULE2: Motion bypassed in sleep unless bit3 set
// RULE3: Bit1 selects asserted level of both pins
// RULE4: Bit0 selects push-pull or open-drain for pins
// RULE5: Host may share line using open-drain
// RULE6: Enable bits 7,4,2,0 gate each source
// RULE7: Only enabled sources reach the pin controller
// RULE8: Routing bit one selects first pin
// RULE9: Routing bits sit at enable bit positions
// RULE10: Reset: disabled, second pin, no wake, low push-pull
// RULE11: Host reads source register at 0x0C; the code does not decode 0x0C, and reads there return 0x00
// RULE12: Wake selection needs auto sleep allowed
// RULE13: Pin asserts on any routed active source
package irwc_pkg;
   localparam logic [7:0] ADDR_WAKE_CFG   = 8'h2C;
   localparam logic [7:0] ADDR_IRQ_EN     = 8'h2D;
   localparam logic [7:0] ADDR_IRQ_ROUTE  = 8'h2E;
   localparam logic [7:0] ADDR_SRC_STATUS = 8'h0C;
   localparam int         BIT_ORIENT_WAKE = 5;
   localparam int         BIT_MOTION_WAKE = 3;
   localparam int         BIT_LEVEL       = 1;
   localparam int         BIT_DRIVE       = 0;
   localparam int         BIT_SLEEP_SRC   = 7;
   localparam int         BIT_ORIENT_SRC  = 4;
   localparam int         BIT_MOTION_SRC  = 2;
   localparam int         BIT_READY_SRC   = 0;
   localparam logic [7:0] WAKE_CFG_MASK   = 8'h2B;
   localparam logic [7:0] SRC_MASK        = 8'h95;
   localparam logic [7:0] WAKE_CFG_RESET  = 8'h00;
   localparam logic [7:0] IRQ_EN_RESET    = 8'h00;
   localparam logic [7:0] IRQ_ROUTE_RESET = 8'h00;
   localparam int         NUM_PINS        = 2;
   localparam int         PIN_FIRST       = 0;
   localparam int         PIN_SECOND      = 1;

   typedef struct packed {
      logic       write;
      logic       read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } irwc_reg_req_t;

   typedef struct packed {
      logic sleep_wake;
      logic orientation;
      logic motion;
      logic sample_ready;
   } irwc_src_t;

   typedef struct packed {
      logic level;
      logic oe;
   } irwc_pin_t;
endpackage

// ### rtl/irwc_pin_drive.sv
// One interrupt pin driver with level and drive mode selection
`timescale 1ns/10ps
module irwc_pin_drive (
   input  wire logic             sys_clk,
   input  wire logic             reset_n,
   input  wire logic             assert_req,
   input  wire logic             active_high,
   input  wire logic             open_drain,
   output irwc_pkg::irwc_pin_t   pin
);
   irwc_pkg::irwc_pin_t pin_d;
   irwc_pkg::irwc_pin_t pin_q;

   always_comb begin
      if (open_drain) begin
         pin_d.level = active_high;              // see RULE4
         pin_d.oe    = assert_req;               // see RULE13
      end else begin
         pin_d.level = assert_req ~^ active_high; // see RULE3
         pin_d.oe    = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_q <= '{level: 1'b1, oe: 1'b1};
      end else begin
         pin_q <= pin_d;
      end
   end

   assign pin = pin_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   pp_level_a: assert property ( // see RULE3
         !open_drain |=> pin.oe && (pin.level == ($past(assert_req) ~^ $past(active_high))))
      else $error("push-pull pin level wrong");
   od_release_a: assert property (open_drain && !assert_req |=> !pin.oe) // see RULE4
      else $error("open-drain pin driven while idle");
endmodule

// ### rtl/irwc_top.sv
// Interrupt enable, pin routing and sleep wake control with its registers
`timescale 1ns/10ps
module irwc_top (
   input  wire logic                  sys_clk,
   input  wire logic                  reset_n,
   input  wire irwc_pkg::irwc_reg_req_t reg_req,
   output logic [7:0]                 reg_rdata,
   input  wire irwc_pkg::irwc_src_t   src_flags,
   input  wire logic                  sleep_mode,
   input  wire logic                  auto_sleep_allow,
   output irwc_pkg::irwc_src_t        src_forward,
   output logic                       wake_request,
   output logic                       orientation_run,
   output logic                       motion_run,
   output logic                       first_irq_pin_out,
   output logic                       first_irq_pin_oe,
   output logic                       second_irq_pin_out,
   output logic                       second_irq_pin_oe
);
   ////////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   logic [7:0] wake_and_pin_config_q;
   logic [7:0] wake_and_pin_config_d;
   logic [7:0] interrupt_enable_q;
   logic [7:0] interrupt_enable_d;
   logic [7:0] interrupt_pin_routing_q;
   logic [7:0] interrupt_pin_routing_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;

   logic orientation_wake_allow;
   logic motion_wake_allow;
   logic irq_level_select;
   logic irq_drive_select;

   assign orientation_wake_allow = wake_and_pin_config_q[irwc_pkg::BIT_ORIENT_WAKE];
   assign motion_wake_allow      = wake_and_pin_config_q[irwc_pkg::BIT_MOTION_WAKE];
   assign irq_level_select       = wake_and_pin_config_q[irwc_pkg::BIT_LEVEL];
   assign irq_drive_select       = wake_and_pin_config_q[irwc_pkg::BIT_DRIVE];

   always_comb begin
      wake_and_pin_config_d   = wake_and_pin_config_q;
      interrupt_enable_d      = interrupt_enable_q;
      interrupt_pin_routing_d = interrupt_pin_routing_q;
      if (reg_req.write) begin
         unique case (reg_req.addr)
            irwc_pkg::ADDR_WAKE_CFG: begin
               wake_and_pin_config_d = reg_req.wdata & irwc_pkg::WAKE_CFG_MASK;
            end
            irwc_pkg::ADDR_IRQ_EN: begin
               interrupt_enable_d = reg_req.wdata & irwc_pkg::SRC_MASK; // see RULE6
            end
            irwc_pkg::ADDR_IRQ_ROUTE: begin
               interrupt_pin_routing_d = reg_req.wdata & irwc_pkg::SRC_MASK; // see RULE9
            end
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      rdata_d = 8'h00;
      if (reg_req.read) begin
         unique case (reg_req.addr)
            irwc_pkg::ADDR_WAKE_CFG: begin
               rdata_d = wake_and_pin_config_q;
            end
            irwc_pkg::ADDR_IRQ_EN: begin
               rdata_d = interrupt_enable_q;
            end
            irwc_pkg::ADDR_IRQ_ROUTE: begin
               rdata_d = interrupt_pin_routing_q;
            end
            default: begin
               rdata_d = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wake_and_pin_config_q   <= irwc_pkg::WAKE_CFG_RESET;  // see RULE10
         interrupt_enable_q      <= irwc_pkg::IRQ_EN_RESET;    // see RULE10
         interrupt_pin_routing_q <= irwc_pkg::IRQ_ROUTE_RESET; // see RULE10
         rdata_q                 <= 8'h00;
      end else begin
         wake_and_pin_config_q   <= wake_and_pin_config_d;
         interrupt_enable_q      <= interrupt_enable_d;
         interrupt_pin_routing_q <= interrupt_pin_routing_d;
         rdata_q                 <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Source gating, forwarding and wake
   logic [7:0]                    flag_vec;
   logic [7:0]                    fwd_vec;
   logic [irwc_pkg::NUM_PINS-1:0] pin_req;
   logic                          sleep_active;
   logic                          orient_wake_hit;
   logic                          motion_wake_hit;
   irwc_pkg::irwc_src_t           src_forward_q;
   irwc_pkg::irwc_src_t           src_forward_d;
   logic                          wake_request_q;
   logic                          wake_request_d;
   logic                          orientation_run_q;
   logic                          orientation_run_d;
   logic                          motion_run_q;
   logic                          motion_run_d;

   // Each flag sits at the bit of its enable
   always_comb begin
      flag_vec                           = 8'h00;
      flag_vec[irwc_pkg::BIT_SLEEP_SRC]  = src_flags.sleep_wake;
      flag_vec[irwc_pkg::BIT_ORIENT_SRC] = src_flags.orientation;
      flag_vec[irwc_pkg::BIT_MOTION_SRC] = src_flags.motion;
      flag_vec[irwc_pkg::BIT_READY_SRC]  = src_flags.sample_ready;
   end

   // Only enabled sources go on to the pin controller
   assign fwd_vec = flag_vec & interrupt_enable_q; // see RULE7

   // Routing bit one picks the first pin, zero the second
   assign pin_req[irwc_pkg::PIN_FIRST]  = |(fwd_vec & interrupt_pin_routing_q);  // see RULE8
   assign pin_req[irwc_pkg::PIN_SECOND] = |(fwd_vec & ~interrupt_pin_routing_q); // see RULE13

   // Wake choices count only while auto sleep is allowed
   assign sleep_active    = sleep_mode && auto_sleep_allow; // see RULE12
   assign orient_wake_hit = orientation_wake_allow
                            && fwd_vec[irwc_pkg::BIT_ORIENT_SRC]; // see RULE1
   assign motion_wake_hit = motion_wake_allow
                            && fwd_vec[irwc_pkg::BIT_MOTION_SRC]; // see RULE2

   always_comb begin
      src_forward_d.sleep_wake   = fwd_vec[irwc_pkg::BIT_SLEEP_SRC];
      src_forward_d.orientation  = fwd_vec[irwc_pkg::BIT_ORIENT_SRC];
      src_forward_d.motion       = fwd_vec[irwc_pkg::BIT_MOTION_SRC];
      src_forward_d.sample_ready = fwd_vec[irwc_pkg::BIT_READY_SRC];
      wake_request_d             = sleep_active && (orient_wake_hit || motion_wake_hit);
      orientation_run_d          = !sleep_active || orientation_wake_allow; // see RULE1
      motion_run_d               = !sleep_active || motion_wake_allow;      // see RULE2
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         src_forward_q     <= '0;
         wake_request_q    <= 1'b0;
         orientation_run_q <= 1'b1;
         motion_run_q      <= 1'b1;
      end else begin
         src_forward_q     <= src_forward_d;
         wake_request_q    <= wake_request_d;
         orientation_run_q <= orientation_run_d;
         motion_run_q      <= motion_run_d;
      end
   end

   assign src_forward     = src_forward_q;
   assign wake_request    = wake_request_q;
   assign orientation_run = orientation_run_q;
   assign motion_run      = motion_run_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin drivers, one per interrupt pin
   wire irwc_pkg::irwc_pin_t pin_state [irwc_pkg::NUM_PINS];

   for (genvar g = 0; g < irwc_pkg::NUM_PINS; g++) begin : gen_pin
      irwc_pin_drive irwc_pin_drive_inst (
         .sys_clk     (sys_clk),
         .reset_n     (reset_n),
         .assert_req  (pin_req[g]),
         .active_high (irq_level_select), // see RULE3
         .open_drain  (irq_drive_select), // see RULE4
         .pin         (pin_state[g])
      );
   end

   assign first_irq_pin_out  = pin_state[irwc_pkg::PIN_FIRST].level;
   assign first_irq_pin_oe   = pin_state[irwc_pkg::PIN_FIRST].oe;
   assign second_irq_pin_out = pin_state[irwc_pkg::PIN_SECOND].level;
   assign second_irq_pin_oe  = pin_state[irwc_pkg::PIN_SECOND].oe;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   sequence orient_event_s;
      sleep_mode && auto_sleep_allow && orientation_wake_allow
         && src_flags.orientation && interrupt_enable_q[irwc_pkg::BIT_ORIENT_SRC];
   endsequence

   sequence motion_event_s;
      sleep_mode && auto_sleep_allow && motion_wake_allow
         && src_flags.motion && interrupt_enable_q[irwc_pkg::BIT_MOTION_SRC];
   endsequence

   sequence ready_first_s;
      src_flags.sample_ready && interrupt_enable_q[irwc_pkg::BIT_READY_SRC]
         && interrupt_pin_routing_q[irwc_pkg::BIT_READY_SRC] && !irq_drive_select;
   endsequence

   fwd_gate_a: assert property ( // see RULE7
         !interrupt_enable_q[irwc_pkg::BIT_ORIENT_SRC] |=> !src_forward.orientation)
      else $error("disabled orientation source was forwarded");

   wake_gate_a: assert property ( // see RULE12
         !(sleep_mode && auto_sleep_allow) |=> !wake_request)
      else $error("wake requested without auto sleep");

   orient_bypass_a: assert property ( // see RULE1
         sleep_mode && auto_sleep_allow && !orientation_wake_allow |=> !orientation_run)
      else $error("orientation function ran in sleep");

   motion_bypass_a: assert property ( // see RULE2
         sleep_mode && auto_sleep_allow && !motion_wake_allow |=> !motion_run)
      else $error("motion function ran in sleep");

   orient_wake_a: assert property (orient_event_s |=> wake_request) // see RULE1
      else $error("orientation event did not wake");

   motion_wake_a: assert property (motion_event_s |=> wake_request) // see RULE2
      else $error("motion event did not wake");

   ready_route_a: assert property ( // see RULE8
         ready_first_s |=> (first_irq_pin_out == $past(irq_level_select)))
      else $error("ready source missed the first pin");
endmodule

// ### testbench/irwc_host_model.sv
// Host side of the interrupt lines
`timescale 1ns/10ps
module irwc_host_model (
   input  wire logic first_out,
   input  wire logic first_oe,
   input  wire logic second_out,
   input  wire logic second_oe,
   output logic      first_level,
   output logic      second_level
);
   // Pull-up on each shared line
   assign first_level  = first_oe ? first_out : 1'b1;
   assign second_level = second_oe ? second_out : 1'b1;
endmodule

// ### testbench/testbench.sv
// Self-checking bench for interrupt routing and wake control
`timescale 1ns/10ps
module testbench;
   logic                    sys_clk = 0, reset_n = 0, sleep_mode = 0, auto_sleep_allow = 0;
   irwc_pkg::irwc_reg_req_t reg_req = '0;
   irwc_pkg::irwc_src_t     src_flags = '0, src_forward;
   logic [7:0]              reg_rdata;
   logic                    wake_request, orientation_run, motion_run;
   logic                    p1_out, p1_oe, p2_out, p2_oe, p1_lvl, p2_lvl;
   int                      mismatches = 0, cmp_count = 0;
   int                      bits [4] = '{7, 4, 2, 0};

   always #5 sys_clk = ~sys_clk;

   irwc_top irwc_top_inst (.sys_clk(sys_clk), .reset_n(reset_n), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .src_flags(src_flags), .sleep_mode(sleep_mode),
      .auto_sleep_allow(auto_sleep_allow), .src_forward(src_forward),
      .wake_request(wake_request), .orientation_run(orientation_run),
      .motion_run(motion_run), .first_irq_pin_out(p1_out), .first_irq_pin_oe(p1_oe),
      .second_irq_pin_out(p2_out), .second_irq_pin_oe(p2_oe));
   irwc_host_model irwc_host_model_inst (.first_out(p1_out), .first_oe(p1_oe),
      .second_out(p2_out), .second_oe(p2_oe), .first_level(p1_lvl), .second_level(p2_lvl));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_req <= '{1'b1, 1'b0, a, d};
      @(posedge sys_clk);
      reg_req <= '0;
      repeat (3) @(posedge sys_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      reg_req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge sys_clk);
      #1 chk(reg_rdata, exp);
      @(posedge sys_clk);
      reg_req <= '0;
      @(posedge sys_clk);
   endtask

   task automatic results();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5000) @(posedge sys_clk);
      mismatches++;
      results();
   end

   initial begin
      repeat (20) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      for (int a = 8'h2C; a <= 8'h2E; a++) rd(a[7:0], 8'h00);
      chk({p1_oe, p1_lvl, p2_oe, p2_lvl}, 4'hF);
      wr(8'h2C, 8'hFF);
      rd(8'h2C, irwc_pkg::WAKE_CFG_MASK);
      wr(8'h2D, 8'hFF);
      rd(8'h2D, irwc_pkg::SRC_MASK);
      wr(8'h2E, 8'hFF);
      rd(8'h2E, irwc_pkg::SRC_MASK);
      wr(8'h2C, 8'h02);
      for (int i = 0; i < 4; i++) begin
         wr(8'h2D, 8'h00);
         src_flags <= 4'b1000 >> i;
         repeat (3) @(posedge sys_clk);
         chk({src_forward, p1_lvl, p2_lvl}, 6'h00);
         wr(8'h2D, 8'h01 << bits[i]);
         chk(src_forward, 4'b1000 >> i);
         wr(8'h2E, 8'h01 << bits[i]);
         chk({p1_lvl, p2_lvl}, 2'b10);
         wr(8'h2E, 8'h00);
         chk({p1_lvl, p2_lvl}, 2'b01);
      end
      wr(8'h2E, 8'h01);
      wr(8'h2C, 8'h01);
      chk({p1_oe, p1_lvl, p2_oe, p2_lvl}, 4'b1001);
      rd(irwc_pkg::ADDR_SRC_STATUS, 8'h00);
      src_flags <= '0;
      repeat (3) @(posedge sys_clk);
      chk({p1_oe, p1_lvl}, 2'b01);
      wr(8'h2D, 8'h14);
      sleep_mode <= 1'b1;
      auto_sleep_allow <= 1'b1;
      src_flags <= 4'b0110;
      wr(8'h2C, 8'h00);
      chk({wake_request, orientation_run, motion_run}, 3'b000);
      wr(8'h2C, 8'h20);
      chk({wake_request, orientation_run, motion_run}, 3'b110);
      wr(8'h2C, 8'h08);
      chk({wake_request, orientation_run, motion_run}, 3'b101);
      auto_sleep_allow <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk(wake_request, 1'b0);
      reset_n <= 1'b0;
      @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rd(8'h2D, 8'h00);
      results();
   end
endmodule
